// *** core/cfg_checksum.sv ***
`timescale 1ns/100ps
module cfg_checksum (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        soft_reset,
  input  wire logic        method_sel,
  // packed bytes, byte 0 in the low bits
  input  wire logic [87:0] cfg_bytes,
  // result
  output logic      [7:0]  sum_q
);

  logic [7:0] byte_val  [link_rx_pkg::CFG_BYTES];
  logic [7:0] field_val [link_rx_pkg::CFG_BYTES];
  logic [7:0] byte_sum;
  logic [7:0] field_sum;

  // -------------------------------------------------------------
  // per byte: raw value and the sum of the fields packed in it
  // -------------------------------------------------------------
  for (genvar i = 0; i < link_rx_pkg::CFG_BYTES; i++) begin : g_byte
    logic [2:0] hs;
    logic [7:0] lo;
    assign byte_val[i] = cfg_bytes[i*8 +: 8];
    assign lo = link_rx_pkg::CFG_LOW_MASK[(10-i)*8 +: 8];
    assign hs = link_rx_pkg::CFG_HI_SHIFT[(10-i)*3 +: 3];
    assign field_val[i] = (byte_val[i] & lo) + ((hs == 3'h0) ? 8'h00 : (byte_val[i] >> hs));
  end

  // mod 256 falls out of the 8-bit accumulators
  always_comb begin
    byte_sum  = 8'h00;
    field_sum = 8'h00;
    for (int i = 0; i < link_rx_pkg::CFG_BYTES; i++) begin
      byte_sum  = byte_sum + byte_val[i];
      field_sum = field_sum + field_val[i];
    end
  end

  // result register, cleared by the link soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q <= 8'h00;
    end else if (soft_reset) begin
      sum_q <= 8'h00;
    end else begin
      sum_q <= method_sel ? byte_sum : field_sum;
    end
  end

  a_cks_fields: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_reset && !method_sel |=> sum_q == $past(field_sum))
    else $error("field checksum wrong");
  a_cks_bytes: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_reset && method_sel |=> sum_q == $past(byte_sum))
    else $error("byte checksum wrong");

endmodule // cfg_checksum

// *** core/link_err_path.sv ***
`timescale 1ns/100ps
module link_err_path (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // controls from the bank
  input  wire logic       soft_reset,
  input  wire logic       force_sync,
  input  wire logic       repl_en,
  input  wire logic       qualify,
  // lane side
  input  wire logic [1:0] lane_sync_in,
  input  wire logic       frame_err,
  input  wire logic       nit_err,
  input  wire logic       rd_err,
  // results
  output logic      [1:0] lane_sync_q,
  output logic            sync_req_q,
  output logic            frame_replace_q,
  output logic            rd_err_rpt_q,
  output logic            ev_sync_lost
);

  // lane sync status, lost while the link is in soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_sync_q <= 2'b00;
    end else begin
      lane_sync_q <= soft_reset ? 2'b00 : lane_sync_in;
    end
  end

  // a lane that was synced and drops raises an event
  assign ev_sync_lost = !soft_reset && |(lane_sync_q & ~lane_sync_in);

  // sync request; also held during reset so the far end restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_req_q <= 1'b0;
    end else begin
      sync_req_q <= force_sync | soft_reset;
    end
  end

  // frame substitution and disparity error reporting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_replace_q <= 1'b0;
      rd_err_rpt_q    <= 1'b0;
    end else begin
      frame_replace_q <= !soft_reset && repl_en && frame_err;
      rd_err_rpt_q    <= !soft_reset && rd_err && !(qualify && nit_err);
    end
  end

  a_lane_sync_track: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_reset |=> lane_sync_q == $past(lane_sync_in))
    else $error("lane sync status not tracking");
  a_soft_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
    soft_reset |=> lane_sync_q == 2'b00 && !frame_replace_q && !rd_err_rpt_q)
    else $error("soft reset did not clear link state");
  a_force_sync_out: assert property (@(posedge pclk) disable iff (!presetn)
    force_sync |=> sync_req_q)
    else $error("forced sync request missing");
  a_frame_replace: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_reset && frame_err |=> frame_replace_q == $past(repl_en))
    else $error("frame replacement wrong");
  a_disparity_plain: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_reset && !qualify && rd_err ##0 nit_err |=> rd_err_rpt_q)
    else $error("disparity error lost with qualify off");

endmodule // link_err_path

// *** core/link_rx_pkg.sv ***
package link_rx_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_LINK_PAGE  = 12'h300;
  localparam logic [11:0] IDX_INIT_SYNC  = 12'h473;
  localparam logic [11:0] IDX_CTRL_MAIN  = 12'h475;
  localparam logic [11:0] IDX_CTRL_ERR   = 12'h476;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h4f0;
  localparam logic [11:0] IDX_IRQ_MASK   = 12'h4f1;
  localparam logic [11:0] IDX_CHECKSUM   = 12'h4f2;
  localparam int unsigned ADDR_W         = 14;

  // ---------------------------------------------------------------
  // field positions, writable masks and reset values
  // ---------------------------------------------------------------
  localparam int unsigned SOFT_RST_BIT   = 3;
  localparam int unsigned FORCE_SYNC_BIT = 2;
  localparam int unsigned REPL_EN_BIT    = 0;
  localparam int unsigned QUALIFY_BIT    = 4;
  localparam int unsigned CKS_SEL_BIT    = 0;
  localparam logic [7:0]  CTRL_MAIN_WMASK = 8'h0d;
  localparam logic [7:0]  CTRL_ERR_WMASK  = 8'h11;
  localparam logic [7:0]  CTRL_MAIN_RST   = 8'h01;
  localparam logic [7:0]  CTRL_ERR_RST    = 8'h10;

  // ---------------------------------------------------------------
  // interrupt events, two per link
  // ---------------------------------------------------------------
  localparam int unsigned EV_SYNC_LOST  = 0;
  localparam int unsigned EV_FRAME_REPL = 1;
  localparam int unsigned EV_PER_LINK   = 2;

  // ---------------------------------------------------------------
  // packed link configuration: 11 bytes, low field mask and
  // shift of the upper field (0 means no upper field)
  // ---------------------------------------------------------------
  localparam int unsigned CFG_BYTES = 11;
  localparam logic [87:0] CFG_LOW_MASK =
    88'hff_0f_1f_1f_ff_1f_ff_1f_1f_1f_1f;
  localparam logic [32:0] CFG_HI_SHIFT =
    33'b000_000_000_111_000_000_000_110_101_101_111;

  // ---------------------------------------------------------------
  // bus phase tracking
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;

endpackage

// *** core/link_rx_regs.sv ***
// What this block does
// - lanes 1 and 0 each report read-only init sync status, resetting to 0.
// - every field except the link page selector and interrupt status and mask is banked per link, chosen by the link page selector.
// - soft reset bit 3 synchronously returns link receiver hardware to reset state.
// - force sync bit 2 makes the receiver assert a sync request.
// - frame replace enable, reset 1, substitutes frames received with errors.
// - with qualify at 0, a not-in-table error leaves disparity reporting alone.
// - checksum method 0 sums the individual configuration fields.
// - checksum method 1 sums packed config bytes 0x450 to 0x45a modulo 256.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module link_rx_regs #(
  parameter int unsigned NUM_LINKS = 2
) (
  // clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // apb slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [link_rx_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                        pwdata,
  output logic                                    pready,
  output logic      [31:0]                        prdata,
  output logic                                    pslverr,
  // lane side inputs, one slice per link
  input  wire logic [2*NUM_LINKS-1:0]             lane_sync_in,
  input  wire logic [NUM_LINKS-1:0]               frame_err,
  input  wire logic [NUM_LINKS-1:0]               nit_err,
  input  wire logic [NUM_LINKS-1:0]               rd_err,
  input  wire logic [88*NUM_LINKS-1:0]            cfg_bytes,
  // link side outputs
  output logic      [NUM_LINKS-1:0]               link_soft_reset,
  output logic      [NUM_LINKS-1:0]               sync_request,
  output logic      [NUM_LINKS-1:0]               frame_replace,
  output logic      [NUM_LINKS-1:0]               rd_err_report,
  output logic      [8*NUM_LINKS-1:0]             cfg_checksum,
  // interrupt
  output logic                                    irq
);

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned PW  = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
  localparam int unsigned EVW = NUM_LINKS * link_rx_pkg::EV_PER_LINK;

  if (NUM_LINKS < 1 || NUM_LINKS > 8) begin : g_bad_links
    $error("NUM_LINKS must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  link_rx_pkg::apb_state_t state_q;
  link_rx_pkg::apb_state_t state_d;
  logic [PW-1:0]           page_q;
  logic [7:0]              ctrl_main_q [NUM_LINKS];
  logic [7:0]              ctrl_err_q  [NUM_LINKS];
  logic [EVW-1:0]          irq_status_q;
  logic [EVW-1:0]          irq_mask_q;
  logic [EVW-1:0]          events;
  logic [1:0]              lane_sync_q [NUM_LINKS];
  logic [7:0]              checksum_q  [NUM_LINKS];
  logic [11:0]             idx;
  logic                    setup;
  logic                    wr_en;
  logic [31:0]             rd_word;
  logic                    rd_bad;

  assign idx   = paddr[link_rx_pkg::ADDR_W-1:2];
  assign setup = psel && !penable;
  // writes take effect at the completing access edge only
  assign wr_en = psel && penable && pwrite && pready && !pslverr;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // unaligned addresses are refused rather than aliased
  function automatic logic is_mapped(input logic [11:0] i, input logic [1:0] lo);
    is_mapped = (lo == 2'b00) &&
                (i == link_rx_pkg::IDX_LINK_PAGE  || i == link_rx_pkg::IDX_INIT_SYNC ||
                 i == link_rx_pkg::IDX_CTRL_MAIN  || i == link_rx_pkg::IDX_CTRL_ERR  ||
                 i == link_rx_pkg::IDX_IRQ_STATUS || i == link_rx_pkg::IDX_IRQ_MASK  ||
                 i == link_rx_pkg::IDX_CHECKSUM);
  endfunction

  function automatic logic wr_hit(input logic [11:0] i, input logic [11:0] reg_idx);
    wr_hit = (i == reg_idx);
  endfunction

  // ---------------------------------------------------------------
  // apb phase tracking: one access cycle, no wait states
  // ---------------------------------------------------------------
  always_comb begin
    case (state_q)
      link_rx_pkg::ST_IDLE:   state_d = setup ? link_rx_pkg::ST_ACCESS : link_rx_pkg::ST_IDLE;
      link_rx_pkg::ST_ACCESS: state_d = setup ? link_rx_pkg::ST_ACCESS : link_rx_pkg::ST_IDLE;
      default:                state_d = link_rx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= link_rx_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ready only once the setup phase has loaded read data
  assign pready = psel && penable && (state_q == link_rx_pkg::ST_ACCESS);

  // ---------------------------------------------------------------
  // link page selector
  // ---------------------------------------------------------------
  // only the low PW bits of the page are kept; a value there beyond the last link is ignored so banks never alias
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= '0;
    end else if (wr_en && wr_hit(idx, link_rx_pkg::IDX_LINK_PAGE)) begin
      if (32'(pwdata[PW-1:0]) < NUM_LINKS) begin
        page_q <= pwdata[PW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // banked control registers, one copy per link
  // ---------------------------------------------------------------
  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_bank
    logic sel;
    assign sel = wr_en && (32'(page_q) == l);

    // reserved bits are masked on write so they stay zero
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_main_q[l] <= link_rx_pkg::CTRL_MAIN_RST;
      end else if (sel && wr_hit(idx, link_rx_pkg::IDX_CTRL_MAIN)) begin
        ctrl_main_q[l] <= pwdata[7:0] & link_rx_pkg::CTRL_MAIN_WMASK;
      end
    end

    // settings are expected to move only during soft reset
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_err_q[l] <= link_rx_pkg::CTRL_ERR_RST;
      end else if (sel && wr_hit(idx, link_rx_pkg::IDX_CTRL_ERR)) begin
        ctrl_err_q[l] <= pwdata[7:0] & link_rx_pkg::CTRL_ERR_WMASK;
      end
    end

    assign link_soft_reset[l] = ctrl_main_q[l][link_rx_pkg::SOFT_RST_BIT];

    // per-link error path: sync, replacement, disparity reporting
    link_err_path u_path (
      .pclk            (pclk),
      .presetn         (presetn),
      .soft_reset      (ctrl_main_q[l][link_rx_pkg::SOFT_RST_BIT]),
      .force_sync      (ctrl_main_q[l][link_rx_pkg::FORCE_SYNC_BIT]),
      .repl_en         (ctrl_main_q[l][link_rx_pkg::REPL_EN_BIT]),
      .qualify         (ctrl_err_q[l][link_rx_pkg::QUALIFY_BIT]),
      .lane_sync_in    (lane_sync_in[2*l +: 2]),
      .frame_err       (frame_err[l]),
      .nit_err         (nit_err[l]),
      .rd_err          (rd_err[l]),
      .lane_sync_q     (lane_sync_q[l]),
      .sync_req_q      (sync_request[l]),
      .frame_replace_q (frame_replace[l]),
      .rd_err_rpt_q    (rd_err_report[l]),
      .ev_sync_lost    (events[l*link_rx_pkg::EV_PER_LINK + link_rx_pkg::EV_SYNC_LOST])
    );

    // configuration checksum in the chosen method
    cfg_checksum u_cks (
      .pclk       (pclk),
      .presetn    (presetn),
      .soft_reset (ctrl_main_q[l][link_rx_pkg::SOFT_RST_BIT]),
      .method_sel (ctrl_err_q[l][link_rx_pkg::CKS_SEL_BIT]),
      .cfg_bytes  (cfg_bytes[88*l +: 88]),
      .sum_q      (checksum_q[l])
    );

    assign cfg_checksum[8*l +: 8] = checksum_q[l];
    assign events[l*link_rx_pkg::EV_PER_LINK + link_rx_pkg::EV_FRAME_REPL] = frame_replace[l];
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else if (wr_en && wr_hit(idx, link_rx_pkg::IDX_IRQ_STATUS)) begin
      irq_status_q <= (irq_status_q & ~pwdata[EVW-1:0]) | events;
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end

  // mask of the same layout, all events off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_en && wr_hit(idx, link_rx_pkg::IDX_IRQ_MASK)) begin
      irq_mask_q <= pwdata[EVW-1:0];
    end
  end

  // level output, no extra flop so clears show at once
  assign irq = |(irq_status_q & irq_mask_q);

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx)
      link_rx_pkg::IDX_LINK_PAGE:  rd_word[PW-1:0]  = page_q;
      link_rx_pkg::IDX_INIT_SYNC:  rd_word[1:0]     = lane_sync_q[page_q];
      link_rx_pkg::IDX_CTRL_MAIN:  rd_word[7:0]     = ctrl_main_q[page_q];
      link_rx_pkg::IDX_CTRL_ERR:   rd_word[7:0]     = ctrl_err_q[page_q];
      link_rx_pkg::IDX_IRQ_STATUS: rd_word[EVW-1:0] = irq_status_q;
      link_rx_pkg::IDX_IRQ_MASK:   rd_word[EVW-1:0] = irq_mask_q;
      link_rx_pkg::IDX_CHECKSUM:   rd_word[7:0]     = checksum_q[page_q];
      default:                     rd_word          = 32'h0000_0000;
    endcase
  end

  assign rd_bad = !is_mapped(idx, paddr[1:0]);

  // loaded in setup so read data leaves a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (pwrite || rd_bad) ? 32'h0000_0000 : rd_word;
      pslverr <= rd_bad;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_page_bank_isolation: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && wr_hit(idx, link_rx_pkg::IDX_CTRL_MAIN) && page_q == '0 && NUM_LINKS > 1
    |=> ctrl_main_q[NUM_LINKS-1] == $past(ctrl_main_q[NUM_LINKS-1]))
    else $error("write leaked into another link bank");

  a_ctrl_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_main_q[0] & ~link_rx_pkg::CTRL_MAIN_WMASK) == 8'h00 &&
    (ctrl_err_q[0] & ~link_rx_pkg::CTRL_ERR_WMASK) == 8'h00)
    else $error("reserved control bits set");

  a_soft_reset_drive: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && wr_hit(idx, link_rx_pkg::IDX_CTRL_MAIN) && page_q == '0 &&
    pwdata[link_rx_pkg::SOFT_RST_BIT] |=> link_soft_reset[0] ##1 sync_request[0])
    else $error("soft reset write not applied");

  a_read_sync_status: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {link_rx_pkg::IDX_INIT_SYNC, 2'b00}
    |=> prdata == {30'h0, $past(lane_sync_q[page_q])})
    else $error("sync status read wrong");

  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    events[0] |=> irq_status_q[0] [*2])
    else $error("event not held in status");

  c_force_sync: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && wr_hit(idx, link_rx_pkg::IDX_CTRL_MAIN) ##2 sync_request[0]);
  c_page_switch: cover property (@(posedge pclk) disable iff (!presetn)
    $changed(page_q) ##[1:20] wr_en && wr_hit(idx, link_rx_pkg::IDX_CTRL_ERR));
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule // link_rx_regs

// *** tb/link_tx_model.sv ***
`timescale 1ns/100ps
// ---------------------------------------------------------------
// transmitter side of two links
// ---------------------------------------------------------------
module link_tx_model #(
  parameter logic [175:0] CFG = '0
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // from the receiver
  input  wire logic [1:0]   sync_request,
  // error injection, one link at a time
  input  wire logic         err_link,
  input  wire logic         fe,
  input  wire logic         ne,
  input  wire logic         re,
  // lane side
  output logic      [3:0]   lane_sync_in,
  output logic      [1:0]   frame_err,
  output logic      [1:0]   nit_err,
  output logic      [1:0]   rd_err,
  output logic      [175:0] cfg_bytes
);
  // lanes drop sync while a request stands, then recover a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_sync_in <= 4'h0;
    end else begin
      lane_sync_in <= {{2{!sync_request[1]}}, {2{!sync_request[0]}}};
    end
  end
  // errors are steered to one link so links can be told apart
  assign frame_err = fe ? (2'b01 << err_link) : 2'b00;
  assign nit_err   = ne ? (2'b01 << err_link) : 2'b00;
  assign rd_err    = re ? (2'b01 << err_link) : 2'b00;
  assign cfg_bytes = CFG;
endmodule // link_tx_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [175:0] CFG = {88'h12_fe_80_e9_41_b6_07_ff_c3_2d_9e,
                                  88'hf3_a5_96_c7_3c_e1_5a_88_77_6b_d4};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, el, fe, ne, re, irq;
  logic [13:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [3:0]   lane_sync_in;
  logic [1:0]   frame_err, nit_err, rd_err, link_soft_reset, sync_request;
  logic [1:0]   frame_replace, rd_err_report;
  logic [175:0] cfg_bytes;
  logic [15:0]  cfg_checksum;
  int           bad_count, cmp_count, cyc;

  link_rx_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lane_sync_in(lane_sync_in), .frame_err(frame_err),
    .nit_err(nit_err), .rd_err(rd_err), .cfg_bytes(cfg_bytes),
    .link_soft_reset(link_soft_reset), .sync_request(sync_request),
    .frame_replace(frame_replace), .rd_err_report(rd_err_report),
    .cfg_checksum(cfg_checksum), .irq(irq));
  link_tx_model #(.CFG(CFG)) u_tx (.pclk(pclk), .presetn(presetn),
    .sync_request(sync_request), .err_link(el), .fe(fe), .ne(ne), .re(re),
    .lane_sync_in(lane_sync_in), .frame_err(frame_err), .nit_err(nit_err),
    .rd_err(rd_err), .cfg_bytes(cfg_bytes));

  always #5 pclk = ~pclk;
  // a hang is cut short well beyond the few hundred cycles of the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; the request is held until pready is sampled high
  task automatic apb(input bit w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    if (pslverr !== 1'b0) r = 32'hdead_0000;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [11:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(n, e, r);
  endtask
  task automatic pulse(input int l, input bit f, input bit n, input bit d);
    @(posedge pclk);
    el <= l[0]; fe <= f; ne <= n; re <= d;
    @(posedge pclk);
    fe <= 1'b0; ne <= 1'b0; re <= 1'b0;
    #1;
  endtask
  // expected checksum: byte sum, or field sum with the upper fields
  function automatic logic [7:0] csum(input logic [87:0] b, input bit raw);
    logic [7:0] s;
    logic [7:0] x;
    int         sh;
    s = 8'h00;
    for (int i = 0; i < 11; i++) begin
      x = b[8*i+:8];
      // the field tables hold byte 0 in their top slot
      sh = link_rx_pkg::CFG_HI_SHIFT[3*(10-i)+:3];
      if (raw) s += x;
      else s += (x & link_rx_pkg::CFG_LOW_MASK[8*(10-i)+:8]) + ((sh != 0) ? (x >> sh) : 8'h00);
    end
    return s;
  endfunction
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    el = 0; fe = 0; ne = 0; re = 0; bad_count = 0; cmp_count = 0; cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc("main reset", link_rx_pkg::IDX_CTRL_MAIN, 32'h01);
    rdc("err reset", link_rx_pkg::IDX_CTRL_ERR, 32'h10);
    for (int l = 0; l < 2; l++) begin
      apb(1'b1, link_rx_pkg::IDX_LINK_PAGE, l);
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h09);
      repeat (2) @(posedge pclk);
      #1 chk("soft reset", 1, link_soft_reset[l]);
      chk("sync in reset", 1, sync_request[l]);
      chk("sum in reset", 0, cfg_checksum[8*l+:8]);
      rdc("sync stat reset", link_rx_pkg::IDX_INIT_SYNC, 0);
      apb(1'b1, link_rx_pkg::IDX_CTRL_ERR, 32'hff);
      rdc("err reserved", link_rx_pkg::IDX_CTRL_ERR, 32'h11);
      if (l == 0) begin
        apb(1'b1, link_rx_pkg::IDX_LINK_PAGE, 1);
        rdc("other bank", link_rx_pkg::IDX_CTRL_ERR, 32'h10);
        apb(1'b1, link_rx_pkg::IDX_LINK_PAGE, 0);
      end
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'hf9);
      rdc("main reserved", link_rx_pkg::IDX_CTRL_MAIN, 32'h09);
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h01);
      repeat (3) @(posedge pclk);
      #1 chk("sum packed", csum(CFG[88*l+:88], 1), cfg_checksum[8*l+:8]);
      rdc("sum bank", link_rx_pkg::IDX_CHECKSUM, csum(CFG[88*l+:88], 1));
      rdc("sync stat", link_rx_pkg::IDX_INIT_SYNC, 3);
      // interrupt raised, masked, unmasked and cleared
      apb(1'b1, link_rx_pkg::IDX_IRQ_STATUS, 32'hff);
      pulse(l, 1, 0, 0);
      chk("replace", 1, frame_replace[l]);
      rdc("irq status", link_rx_pkg::IDX_IRQ_STATUS, 32'h1 << (2*l+1));
      chk("irq masked", 0, irq);
      apb(1'b1, link_rx_pkg::IDX_IRQ_MASK, 32'hff);
      #1 chk("irq open", 1, irq);
      apb(1'b1, link_rx_pkg::IDX_IRQ_STATUS, 32'hff);
      #1 chk("irq clear", 0, irq);
      apb(1'b1, link_rx_pkg::IDX_IRQ_MASK, 32'h00);
      pulse(l, 0, 1, 1);
      chk("rd qualified", 0, rd_err_report[l]);
      pulse(l, 0, 0, 1);
      chk("rd alone", 1, rd_err_report[l]);
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h09);
      apb(1'b1, link_rx_pkg::IDX_CTRL_ERR, 32'h00);
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h01);
      repeat (3) @(posedge pclk);
      #1 chk("sum fields", csum(CFG[88*l+:88], 0), cfg_checksum[8*l+:8]);
      pulse(l, 0, 1, 1);
      chk("rd unqualified", 1, rd_err_report[l]);
      // force sync on a running link so synced lanes really drop
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h05);
      repeat (3) @(posedge pclk);
      #1 chk("force sync", 1, sync_request[l]);
      chk("no soft reset", 0, link_soft_reset[l]);
      rdc("sync lost", link_rx_pkg::IDX_INIT_SYNC, 0);
      rdc("irq sync lost", link_rx_pkg::IDX_IRQ_STATUS, 32'h1 << (2*l));
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h09);
      apb(1'b1, link_rx_pkg::IDX_CTRL_ERR, 32'h10);
      apb(1'b1, link_rx_pkg::IDX_CTRL_MAIN, 32'h01);
    end
    // unmapped place is refused
    apb(1'b0, 12'h123, 32'h0);
    chk("unmapped", 32'hdead_0000, r);
    conclude();
  end
endmodule // testbench
